/* File: logic/txb_ctrl.sv */
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
// Overview of operation
// - after search, at most two buffers go from idle to available for next slot
// - frame sent at slot start only from available buffer with commit set
// - header length above segment size: read twice segment size, pad the rest
// - header length within segment size: read exactly twice header length bytes
// - static slot owned on channel A when some buffer matches id with A enabled
// - owned slot sends null frame if all matches uncommitted, locked or filtered
// - host may uncommit an available buffer; it then serves a null frame
// - null conditions after search: at most two buffers become slot assigned
// - slot assigned buffer at slot start always yields a null frame
// - lock changes during null frame service leave the null frame untouched
// - slot status vector after each slot drives the buffer status update
// - complete transmission: store slot status, status update, set interrupt flag
// - event mode: message sent once, commit cleared at status update
// - state mode: commit kept, data valid set, message resent
// - incomplete transmission leaves status, flags and interrupt flag unchanged
// - internal error on incomplete transmission sets engine failure flag
// - null frame leaves its buffer status, flags and interrupt flag unchanged
// - entering a locked state clears the data valid flag
// - transmission start beats a simultaneous host lock in available state
module txb_ctrl (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  // register port
  input  wire logic [7:0]                 addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [31:0]                rdata,
  // search results from buffer search
  input  wire logic                       search_done,
  input  wire logic [1:0]                 ma_en,
  input  wire logic [txb_pkg::IW-1:0]     ma_idx0,
  input  wire logic [txb_pkg::IW-1:0]     ma_idx1,
  input  wire logic [1:0]                 sa_en,
  input  wire logic [txb_pkg::IW-1:0]     sa_idx0,
  input  wire logic [txb_pkg::IW-1:0]     sa_idx1,
  // current slot from protocol engine
  input  wire logic [txb_pkg::FIDW-1:0]   cur_slot_id,
  input  wire logic [txb_pkg::CYCW-1:0]   cur_cycle,
  input  wire logic                       slot_start,
  input  wire logic                       slot_end,
  input  wire logic [txb_pkg::SSW-1:0]    slot_status,
  input  wire logic                       tx_complete,
  input  wire logic                       tx_int_error,
  // frame request toward protocol engine
  output logic                            frame_start,
  output logic                            null_start,
  output logic      [txb_pkg::IW-1:0]     tx_idx,
  output logic      [txb_pkg::RBW-1:0]    read_bytes,
  output logic                            zero_pad,
  // channel A static slot status
  output logic                            slot_owned_a,
  output logic                            null_frame_a,
  // flag for protocol irq flags one
  output logic                            engine_comm_failure_flag
);
  import txb_pkg::*;

  // per-buffer storage
  logic [31:0]     cfg_reg     [NB];
  logic [LENW-1:0] hdr_len_reg [NB];
  txb_state_t      state_reg   [NB];
  logic [SSW-1:0]  sstat_reg   [NB];
  logic [NB-1:0]   commit_bit;
  logic [NB-1:0]   lock_status;
  logic [NB-1:0]   data_valid_flag;
  logic [NB-1:0]   buffer_interrupt_flag;

  logic [LENW-1:0] seg1_ds_reg;
  logic [LENW-1:0] seg2_ds_reg;
  logic            pecf_reg;

  // per-buffer decoded events
  logic [NB-1:0]   ma_hit;
  logic [NB-1:0]   sa_hit;
  logic [NB-1:0]   tx_fire;
  logic [NB-1:0]   su_ok;
  logic [NB-1:0]   ctl_wr;
  logic [NB-1:0]   slot_match;
  logic [NB-1:0]   null_cond;

  // slot start selection
  logic            sel_any;
  logic            sel_data;
  logic [IW-1:0]   sel_idx;
  logic [RBW-1:0]  calc_bytes;
  logic            calc_pad;

  wire cfg_sel  = addr[7:2] == ADDR_CFG_BASE[7:2];
  wire ctl_sel  = addr[7:2] == ADDR_CTL_BASE[7:2];
  wire hdr_sel  = addr[7:2] == ADDR_HDR_BASE[7:2];
  wire stat_sel = addr[7:2] == ADDR_STAT_BASE[7:2];
  wire [IW-1:0] aidx = addr[IW-1:0];

  genvar n;
  generate
    for (n = 0; n < NB; n++) begin : g_buf
      localparam logic [IW-1:0] ID = IW'(n);
      wire lck_trig = ctl_wr[n] & wdata[CTL_LCK_BIT];

      // search results name at most two buffers each way
      assign ma_hit[n] = search_done & ((ma_en[0] & (ma_idx0 == ID)) |
                                        (ma_en[1] & (ma_idx1 == ID)));
      assign sa_hit[n] = search_done & ((sa_en[0] & (sa_idx0 == ID)) |
                                        (sa_en[1] & (sa_idx1 == ID)));
      assign ctl_wr[n] = wr_en & ctl_sel & (aidx == ID);
      // a locked available buffer counts as host-held and sends no data
      assign tx_fire[n] = slot_start & (state_reg[n] == ST_AVAIL) &
                          commit_bit[n] & ~lock_status[n];
      assign su_ok[n]   = slot_end & (state_reg[n] == ST_TX) & tx_complete;

      // channel A ownership and null conditions per buffer
      assign slot_match[n] = (cfg_reg[n][CFG_FID_LSB +: FIDW] == cur_slot_id) &
                             cfg_reg[n][CFG_CHA_BIT];
      assign null_cond[n]  = ~commit_bit[n] | lock_status[n] |
                             (cfg_reg[n][CFG_CFE_BIT] &
                              (cfg_reg[n][CFG_CYC_LSB +: CYCW] != cur_cycle));

      // configuration and header length words
      // the host is expected to reconfigure only buffers that are idle or locked
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          cfg_reg[n]     <= RST_CFG;
          hdr_len_reg[n] <= RST_LEN;
        end else begin
          if (wr_en && cfg_sel && aidx == ID) begin
            cfg_reg[n] <= wdata;
          end
          if (wr_en && hdr_sel && aidx == ID) begin
            hdr_len_reg[n] <= wdata[LENW-1:0];
          end
        end
      end

      // buffer state; lock is a separate bit so null service ignores it
      // ma beats sa; a locked idle buffer can only reach the slot assigned path
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          state_reg[n] <= ST_IDLE;
        end else begin
          unique case (state_reg[n])
            ST_IDLE: begin
              if (ma_hit[n] && !lock_status[n]) begin
                state_reg[n] <= ST_AVAIL;
              end else if (sa_hit[n]) begin
                state_reg[n] <= ST_SLOT_ASG;
              end
            end
            ST_AVAIL: begin
              if (tx_fire[n]) begin
                state_reg[n] <= ST_TX;
              end else if (slot_start) begin
                state_reg[n] <= ST_NULL;
              end
            end
            ST_SLOT_ASG: begin
              if (slot_start) begin
                state_reg[n] <= ST_NULL;
              end
            end
            ST_TX, ST_NULL: begin
              if (slot_end) begin
                state_reg[n] <= ST_IDLE;
              end
            end
          endcase
        end
      end

      // lock toggles; ignored while transmitting or when a start fires
      // an ignored toggle is lost, so the host must issue it again
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          lock_status[n] <= 1'b0;
        end else if (lck_trig && state_reg[n] != ST_TX && !tx_fire[n]) begin
          lock_status[n] <= ~lock_status[n];
        end
      end

      // commit: host sets or clears, event mode clears at status update
      // a fresh host commit beats the hardware clear so new data is never dropped
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          commit_bit[n] <= 1'b0;
        end else if (ctl_wr[n] && wdata[CTL_CSET_BIT]) begin
          commit_bit[n] <= 1'b1;
        end else if (ctl_wr[n] && wdata[CTL_CCLR_BIT]) begin
          commit_bit[n] <= 1'b0;
        end else if (su_ok[n] && !cfg_reg[n][CFG_MTM_BIT]) begin
          commit_bit[n] <= 1'b0;
        end
      end

      // data valid: lock clears it, state mode completion sets it
      // unlocking leaves the flag alone; only the lock direction clears it
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          data_valid_flag[n] <= 1'b0;
        end else if (lck_trig && !lock_status[n] && state_reg[n] != ST_TX &&
                     !tx_fire[n]) begin
          data_valid_flag[n] <= 1'b0;
        end else if (su_ok[n] && cfg_reg[n][CFG_MTM_BIT]) begin
          data_valid_flag[n] <= 1'b1;
        end
      end

      // interrupt flag: hardware set wins over a same-cycle host clear
      // the clear is a write-one trigger, so other control bits may share the word
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          buffer_interrupt_flag[n] <= 1'b0;
        end else if (su_ok[n]) begin
          buffer_interrupt_flag[n] <= 1'b1;
        end else if (ctl_wr[n] && wdata[CTL_IFC_BIT]) begin
          buffer_interrupt_flag[n] <= 1'b0;
        end
      end

      // slot status only on complete data frames; null and partial keep it
      // an incomplete slot must not overwrite the last good status vector
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          sstat_reg[n] <= RST_SS;
        end else if (su_ok[n]) begin
          sstat_reg[n] <= slot_status;
        end
      end
    end
  endgenerate

  // segment data sizes
  // one shared pair for all buffers; the segment bit of each buffer picks one
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seg1_ds_reg <= RST_LEN;
      seg2_ds_reg <= RST_LEN;
    end else if (wr_en && addr == ADDR_SEG) begin
      seg1_ds_reg <= wdata[SEG1_LSB +: LENW];
      seg2_ds_reg <= wdata[SEG2_LSB +: LENW];
    end
  end

  // failure flag: set by an internal error at a slot end without tx_complete, set beats clear
  // sticky so a short fault is still seen by slow host polling
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pecf_reg <= 1'b0;
    end else if (slot_end && tx_int_error && !tx_complete) begin
      pecf_reg <= 1'b1;
    end else if (wr_en && addr == ADDR_PEFLAG && wdata[PEF_BIT]) begin
      pecf_reg <= 1'b0;
    end
  end
  assign engine_comm_failure_flag = pecf_reg;

  // pick the lowest buffer that serves this slot; search may name two per slot
  // limitation: a second available buffer still changes state in the slot,
  // but only the lowest index reaches the engine
  always_comb begin
    sel_any  = 1'b0;
    sel_data = 1'b0;
    sel_idx  = '0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (state_reg[i] == ST_AVAIL || state_reg[i] == ST_SLOT_ASG) begin
        sel_any  = 1'b1;
        sel_data = tx_fire[i];
        sel_idx  = IW'(i);
      end
    end
  end

  // length mux follows the selected buffer, ready at the slot start edge
  txb_payload_len u_len (
    .header_payload_length (hdr_len_reg[sel_idx]),
    .segment_one_data_size (seg1_ds_reg),
    .segment_two_data_size (seg2_ds_reg),
    .seg_sel               (cfg_reg[sel_idx][CFG_SEG_BIT]),
    .read_bytes            (calc_bytes),
    .zero_pad              (calc_pad)
  );

  // frame request, one-cycle pulses with the selection held after
  // length and index are latched so the engine may fetch after the pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frame_start <= 1'b0;
      null_start  <= 1'b0;
      tx_idx      <= '0;
      read_bytes  <= '0;
      zero_pad    <= 1'b0;
    end else begin
      frame_start <= slot_start & sel_any & sel_data;
      null_start  <= slot_start & sel_any & ~sel_data;
      if (slot_start && sel_any) begin
        tx_idx     <= sel_idx;
        read_bytes <= sel_data ? calc_bytes : '0;
        zero_pad   <= sel_data & calc_pad;
      end
    end
  end

  // channel A ownership of the current static slot, registered
  // one cycle behind the slot id and buffer state, which the engine allows for
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slot_owned_a <= 1'b0;
      null_frame_a <= 1'b0;
    end else begin
      slot_owned_a <= |slot_match;
      null_frame_a <= (|slot_match) & ~|(slot_match & ~null_cond);
    end
  end

  // read data valid from the cycle after the strobe, held until the next read strobe
  // unmapped words and the write-only control words read as zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata <= 32'h0000_0000;
      if (cfg_sel) begin
        rdata <= cfg_reg[aidx];
      end else if (hdr_sel) begin
        rdata[LENW-1:0] <= hdr_len_reg[aidx];
      end else if (stat_sel) begin
        rdata[STAT_ST_LSB +: 3]   <= state_reg[aidx];
        rdata[STAT_CMT_BIT]       <= commit_bit[aidx];
        rdata[STAT_LCK_BIT]       <= lock_status[aidx];
        rdata[STAT_DV_BIT]        <= data_valid_flag[aidx];
        rdata[STAT_IF_BIT]        <= buffer_interrupt_flag[aidx];
        rdata[STAT_SS_LSB +: SSW] <= sstat_reg[aidx];
      end else if (addr == ADDR_SEG) begin
        rdata[SEG1_LSB +: LENW] <= seg1_ds_reg;
        rdata[SEG2_LSB +: LENW] <= seg2_ds_reg;
      end else if (addr == ADDR_PEFLAG) begin
        rdata[PEF_BIT] <= pecf_reg;
      end
    end
  end
endmodule

/* File: logic/txb_pkg.sv */
package txb_pkg;
  // buffer count and field widths
  localparam int NB   = 4;
  localparam int IW   = 2;
  localparam int FIDW = 11;
  localparam int LENW = 7;
  localparam int CYCW = 6;
  localparam int SSW  = 16;
  localparam int RBW  = 8;

  // word addresses on the register port; each group holds NB words
  localparam logic [7:0] ADDR_CFG_BASE  = 8'h00;
  localparam logic [7:0] ADDR_CTL_BASE  = 8'h08;
  localparam logic [7:0] ADDR_HDR_BASE  = 8'h10;
  localparam logic [7:0] ADDR_STAT_BASE = 8'h18;
  localparam logic [7:0] ADDR_SEG       = 8'h20;
  localparam logic [7:0] ADDR_PEFLAG    = 8'h24;

  // configuration word fields
  localparam int CFG_FID_LSB = 0;
  localparam int CFG_CHA_BIT = 11;
  localparam int CFG_MTM_BIT = 12;
  localparam int CFG_SEG_BIT = 13;
  localparam int CFG_CFE_BIT = 14;
  localparam int CFG_CYC_LSB = 16;

  // control word bits, all write-one triggers
  localparam int CTL_CSET_BIT = 0;
  localparam int CTL_CCLR_BIT = 1;
  localparam int CTL_LCK_BIT  = 2;
  localparam int CTL_IFC_BIT  = 3;

  // status word fields
  localparam int STAT_ST_LSB  = 0;
  localparam int STAT_CMT_BIT = 4;
  localparam int STAT_LCK_BIT = 5;
  localparam int STAT_DV_BIT  = 6;
  localparam int STAT_IF_BIT  = 7;
  localparam int STAT_SS_LSB  = 16;

  // segment data size word fields
  localparam int SEG1_LSB = 0;
  localparam int SEG2_LSB = 8;

  // flag word bit
  localparam int PEF_BIT = 0;

  // reset values
  localparam logic [31:0]   RST_CFG  = 32'h0000_0000;
  localparam logic [LENW-1:0] RST_LEN = 7'h00;
  localparam logic [SSW-1:0] RST_SS  = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_AVAIL,
    ST_SLOT_ASG,
    ST_TX,
    ST_NULL
  } txb_state_t;
endpackage

/* File: logic/txb_payload_len.sv */
`timescale 1ns/100ps
// bytes to fetch from buffer memory for one frame, and whether padding follows
module txb_payload_len (
  // header length and segment data sizes, in two-byte words
  input  wire logic [txb_pkg::LENW-1:0] header_payload_length,
  input  wire logic [txb_pkg::LENW-1:0] segment_one_data_size,
  input  wire logic [txb_pkg::LENW-1:0] segment_two_data_size,
  input  wire logic                     seg_sel,
  // result
  output logic      [txb_pkg::RBW-1:0]  read_bytes,
  output logic                          zero_pad
);
  import txb_pkg::*;

  logic [LENW-1:0] seg_ds;

  // segment picks the size limit; both segments behave alike
  always_comb begin
    seg_ds = seg_sel ? segment_two_data_size : segment_one_data_size;
    if (header_payload_length > seg_ds) begin
      read_bytes = {seg_ds, 1'b0};
      zero_pad   = 1'b1;
    end else begin
      read_bytes = {header_payload_length, 1'b0};
      zero_pad   = 1'b0;
    end
  end
endmodule

/* File: bench/txb_chk.sv */
`timescale 1ns/100ps
// port-level watchers for frame requests and the sticky failure flag
module txb_chk (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  // register port
  input  wire logic [7:0]              addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr_en,
  // engine side
  input  wire logic                    slot_start,
  input  wire logic                    slot_end,
  input  wire logic                    tx_complete,
  input  wire logic                    tx_int_error,
  input  wire logic                    frame_start,
  input  wire logic                    null_start,
  input  wire logic [txb_pkg::RBW-1:0] read_bytes,
  input  wire logic                    engine_comm_failure_flag
);
  import txb_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // a slot that ended short by an internal fault
  sequence s_bad_end;
    slot_end && tx_int_error && !tx_complete;
  endsequence
  // the request follows its slot start by exactly one edge
  sequence s_slot_begin;
    slot_start ##1 1'b1;
  endsequence
  chk_frame_cause: assert property (frame_start |-> $past(slot_start))
    else $error("frame request without slot start");
  chk_null_cause: assert property (null_start |-> $past(slot_start))
    else $error("null request without slot start");
  chk_start_excl: assert property (s_slot_begin |-> !(frame_start && null_start))
    else $error("frame and null requested together");
  chk_even_bytes: assert property (frame_start |-> read_bytes[0] == 1'b0)
    else $error("odd read length");
  chk_null_bytes: assert property (null_start |-> read_bytes == 8'h00)
    else $error("null frame reads buffer data");
  chk_fail_set: assert property (s_bad_end |=> engine_comm_failure_flag)
    else $error("failure flag not set");
  chk_fail_cause: assert property ($rose(engine_comm_failure_flag) |->
    $past(slot_end && tx_int_error && !tx_complete))
    else $error("failure flag set without cause");
  chk_fail_hold: assert property (engine_comm_failure_flag &&
    !(wr_en && addr == ADDR_PEFLAG && wdata[PEF_BIT]) |=> engine_comm_failure_flag)
    else $error("failure flag dropped");
endmodule

bind txb_ctrl txb_chk u_chk (.*);

/* File: bench/txb_pe_model.sv */
`timescale 1ns/100ps
// engine stand-in: search pulses, slot bounds and the slot status vector
module txb_pe_model (
  // clock
  input  wire logic                     sys_clk,
  // search results
  output logic                          search_done,
  output logic      [1:0]               ma_en,
  output logic      [txb_pkg::IW-1:0]   ma_idx0,
  output logic      [txb_pkg::IW-1:0]   ma_idx1,
  output logic      [1:0]               sa_en,
  output logic      [txb_pkg::IW-1:0]   sa_idx0,
  output logic      [txb_pkg::IW-1:0]   sa_idx1,
  // slot timing and status
  output logic      [txb_pkg::FIDW-1:0] cur_slot_id,
  output logic      [txb_pkg::CYCW-1:0] cur_cycle,
  output logic                          slot_start,
  output logic                          slot_end,
  output logic      [txb_pkg::SSW-1:0]  slot_status,
  output logic                          tx_complete,
  output logic                          tx_int_error
);
  import txb_pkg::*;
  initial begin
    {search_done, ma_en, ma_idx0, ma_idx1, sa_en, sa_idx0, sa_idx1} = '0;
    {cur_slot_id, cur_cycle, slot_start, slot_end, slot_status} = '0;
    {tx_complete, tx_int_error} = '0;
  end
  // indices are scrambled after the pulse so nothing leans on stale values
  task automatic search(input logic [1:0] m, input logic [IW-1:0] m0, m1,
                        input logic [1:0] s, input logic [IW-1:0] s0);
    {ma_en, ma_idx0, ma_idx1, sa_en, sa_idx0} <= {m, m0, m1, s, s0};
    search_done <= 1'b1;
    @(posedge sys_clk);
    search_done <= 1'b0;
    {ma_idx0, ma_idx1, sa_idx0, sa_idx1} <= {~m0, ~m1, ~s0, ~s0};
    @(posedge sys_clk);
  endtask
  // returns at the start edge so the caller still sees the one-cycle request
  task automatic begin_slot(input logic [FIDW-1:0] id);
    cur_slot_id <= id;
    slot_start  <= 1'b1;
    @(posedge sys_clk);
    slot_start <= 1'b0;
  endtask
  // ownership probes move the slot id without a slot start
  task automatic set_slot(input logic [FIDW-1:0] id);
    cur_slot_id <= id;
  endtask
  // gap stretches the slot to mimic a slow engine
  task automatic end_slot(input logic c, e, input logic [SSW-1:0] ss, input int gap);
    repeat (gap) @(posedge sys_clk);
    {tx_complete, tx_int_error, slot_status} <= {c, e, ss};
    slot_end <= 1'b1;
    @(posedge sys_clk);
    slot_end <= 1'b0;
    {tx_complete, tx_int_error, slot_status} <= {~c, ~e, ~ss};
    @(posedge sys_clk);
  endtask
endmodule

/* File: bench/txb_ctrl_tb_top.sv */
`timescale 1ns/100ps
module txb_ctrl_tb_top;
  import txb_pkg::*;
  // clock, reset and register port
  logic             sys_clk, rstn, wr_en, rd_en;
  logic [7:0]       addr;
  logic [31:0]      wdata, rdata;
  // engine side
  logic             search_done, slot_start, slot_end, tx_complete, tx_int_error;
  logic [1:0]       ma_en, sa_en;
  logic [IW-1:0]    ma_idx0, ma_idx1, sa_idx0, sa_idx1, tx_idx;
  logic [FIDW-1:0]  cur_slot_id;
  logic [CYCW-1:0]  cur_cycle;
  logic [SSW-1:0]   slot_status;
  logic             frame_start, null_start, zero_pad;
  logic             slot_owned_a, null_frame_a, engine_comm_failure_flag;
  logic [RBW-1:0]   read_bytes;
  int               num_errors, checked;

  txb_ctrl DUT (.*);
  txb_pe_model pe (.*);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one write cycle, then one idle cycle so strobes never reassert in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {addr, wdata, wr_en} <= {a, d, 1'b1};
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    {addr, rd_en} <= {a, 1'b1};
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 check(rdata, exp);
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] st(logic [2:0] s, logic c, l, d, i, logic [15:0] ss);
    return {ss, 8'h00, i, d, l, c, 1'b0, s};
  endfunction
  // request outputs in the cycle after the slot start edge
  task automatic slot_chk(input logic f, n, input logic [IW-1:0] i,
                          input logic [RBW-1:0] b, input logic z);
    #1;
    check(frame_start, f);
    check(null_start, n);
    check(tx_idx, i);
    check(read_bytes, b);
    if (f)
      check(zero_pad, z);
    @(posedge sys_clk);
  endtask
  task automatic own_chk(input logic [FIDW-1:0] id, input logic o, n);
    pe.set_slot(id);
    repeat (3) @(posedge sys_clk);
    #1 check(slot_owned_a, o);
    check(null_frame_a, n);
  endtask

  initial begin
    {rstn, addr, wdata, wr_en, rd_en} = '0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_STAT_BASE, st(0, 0, 0, 0, 0, 0));
    rd(8'h30, 32'h0);
    wr(ADDR_SEG, 32'h0000_0804);
    // event mode, length within segment one
    wr(ADDR_CFG_BASE, 32'h0000_0805);
    wr(ADDR_HDR_BASE, 32'h3);
    wr(ADDR_CTL_BASE, 32'h1);
    pe.search(2'b01, 0, 0, 2'b00, 0);
    rd(ADDR_STAT_BASE, st(1, 1, 0, 0, 0, 0));
    pe.begin_slot(11'd5);
    slot_chk(1, 0, 0, 8'd6, 0);
    rd(ADDR_STAT_BASE, st(3, 1, 0, 0, 0, 0));
    pe.end_slot(1, 0, 16'h00a5, 0);
    rd(ADDR_STAT_BASE, st(0, 0, 0, 0, 1, 16'h00a5));
    // state mode over segment two beside an aborted buffer
    wr(ADDR_CFG_BASE + 8'h1, 32'h0000_3806);
    wr(ADDR_HDR_BASE + 8'h1, 32'ha);
    wr(ADDR_CTL_BASE + 8'h1, 32'h1);
    wr(ADDR_CFG_BASE + 8'h2, 32'h0000_0806);
    wr(ADDR_CTL_BASE + 8'h2, 32'h1);
    pe.search(2'b11, 1, 2, 2'b00, 0);
    rd(ADDR_STAT_BASE + 8'h2, st(1, 1, 0, 0, 0, 0));
    wr(ADDR_CTL_BASE + 8'h2, 32'h2);
    rd(ADDR_STAT_BASE + 8'h1, st(1, 1, 0, 0, 0, 0));
    pe.begin_slot(11'd6);
    slot_chk(1, 0, 1, 8'd16, 1);
    rd(ADDR_STAT_BASE + 8'h2, st(4, 0, 0, 0, 0, 0));
    pe.end_slot(1, 0, 16'h0011, 5);
    rd(ADDR_STAT_BASE + 8'h1, st(0, 1, 0, 1, 1, 16'h0011));
    // the aborted buffer went null unreported; name it alone for the next slot
    pe.search(2'b01, 2, 0, 2'b00, 0);
    pe.begin_slot(11'd6);
    slot_chk(0, 1, 2, 8'd0, 0);
    pe.end_slot(1, 0, 16'h0022, 0);
    rd(ADDR_STAT_BASE + 8'h2, st(0, 0, 0, 0, 0, 0));
    wr(ADDR_CTL_BASE + 8'h1, 32'h4);
    rd(ADDR_STAT_BASE + 8'h1, st(0, 1, 1, 0, 1, 16'h0011));
    // lock lands on the slot start edge, then the slot fails
    wr(ADDR_CTL_BASE, 32'h1);
    pe.search(2'b01, 0, 0, 2'b00, 0);
    {addr, wdata, wr_en} <= {ADDR_CTL_BASE, 32'h0000_0004, 1'b1};
    pe.begin_slot(11'd5);
    wr_en <= 1'b0;
    slot_chk(1, 0, 0, 8'd6, 0);
    rd(ADDR_STAT_BASE, st(3, 1, 0, 0, 1, 16'h00a5));
    pe.end_slot(0, 1, 16'h00ff, 0);
    rd(ADDR_STAT_BASE, st(0, 1, 0, 0, 1, 16'h00a5));
    wr(ADDR_CTL_BASE, 32'h8);
    rd(ADDR_STAT_BASE, st(0, 1, 0, 0, 0, 16'h00a5));
    rd(ADDR_PEFLAG, 32'h1);
    wr(ADDR_PEFLAG, 32'h1);
    rd(ADDR_PEFLAG, 32'h0);
    // locked buffer assigned to a slot, unlocked and committed before it
    wr(ADDR_CFG_BASE + 8'h3, 32'h0000_0807);
    wr(ADDR_CTL_BASE + 8'h3, 32'h4);
    pe.search(2'b00, 0, 0, 2'b01, 3);
    rd(ADDR_STAT_BASE + 8'h3, st(2, 0, 1, 0, 0, 0));
    wr(ADDR_CTL_BASE + 8'h3, 32'h4);
    wr(ADDR_CTL_BASE + 8'h3, 32'h1);
    pe.begin_slot(11'd7);
    slot_chk(0, 1, 3, 8'd0, 0);
    wr(ADDR_CTL_BASE + 8'h3, 32'h4);
    pe.end_slot(1, 0, 16'h0033, 0);
    rd(ADDR_STAT_BASE + 8'h3, st(0, 1, 1, 0, 0, 0));
    // channel A ownership: locked match, committed match, no match
    own_chk(11'd7, 1, 1);
    own_chk(11'd5, 1, 0);
    wr(ADDR_CFG_BASE, 32'h0001_4805);
    own_chk(11'd5, 1, 1);
    wr(ADDR_CFG_BASE, 32'h0000_4805);
    own_chk(11'd5, 1, 0);
    own_chk(11'd9, 0, 0);
    tally_and_finish();
  end
  // the whole sequence needs well under 2000 cycles
  initial begin
    #100us;
    num_errors++;
    tally_and_finish();
  end
endmodule
